//--- hw/bit_sync.sv
// Two-stage synchroniser for one asynchronous pin
`default_nettype none

module bit_sync
#(
	parameter logic RESET_VAL = 1'h1
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Pin and synchronised level
	input wire logic d_i,
	output logic q_o
);

	typedef struct packed
	{
		logic meta;
		logic q;
	} sync_regs_t;

	sync_regs_t s;
	sync_regs_t next_;

	always_comb
	begin
		next_.meta = d_i;
		next_.q = s.meta;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s <= {RESET_VAL, RESET_VAL};
		end
		else
		begin
			s <= next_;
		end
	end

	assign q_o = s.q;

endmodule

`default_nettype wire

//--- hw/fieldbus_serial_uart.sv
// Top of the fieldbus serial UART: transmitter, telegram handshake and receiver hookup
`default_nettype none

module fieldbus_serial_uart
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,

	// Configuration
	input wire logic [fieldbus_uart_pkg::QDIV_W-1:0] quarter_div_i,
	input wire logic stop_check_dis_i,
	input wire logic start_check_dis_i,

	// Transmit character stream
	input wire logic [7:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,

	// Received character stream
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	output logic rx_parity_err_o,
	output logic rx_frame_err_o,

	// Line transceiver and modem
	input wire logic rxd_i,
	input wire logic modem_clear_in_n_i,
	output logic txd_o,
	output logic txd_oe_o,
	output logic rts_o
);
	import fieldbus_uart_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed
	{
		tx_state_t st;
		logic [QDIV_W-1:0] div;
		logic [1:0] qcnt;
		logic [3:0] bitcnt;
		logic [10:0] shreg;
		logic [7:0] cur;
		logic [7:0] hold;
		logic hold_valid;
		logic tx_ready;
		logic txd;
		logic oe;
		logic rts;
	} tx_regs_t;

	tx_regs_t s;
	tx_regs_t next_;
	logic cts_n;
	logic rxd_sync;
	logic tx_tick;
	logic end_of_char;
	logic tx_load;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	bit_sync #(.RESET_VAL(CTS_INACTIVE)) u_cts_sync
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(modem_clear_in_n_i),
		.q_o(cts_n)
	);

	bit_sync #(.RESET_VAL(LINE_IDLE)) u_rxd_sync
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(rxd_i),
		.q_o(rxd_sync)
	);

	// ****************************************************************
	// Receiver
	// ****************************************************************
	serial_receiver u_rx
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.rxd_i(rxd_sync),
		.quarter_div_i(quarter_div_i),
		.stop_check_dis_i(stop_check_dis_i),
		.start_check_dis_i(start_check_dis_i),
		.data_o(rx_data_o),
		.valid_o(rx_valid_o),
		.parity_err_o(rx_parity_err_o),
		.frame_err_o(rx_frame_err_o)
	);

	// ****************************************************************
	// Transmitter
	// ****************************************************************
	// The divider is restarted with each character, so every bit is exactly four quarters
	assign tx_tick = (s.div == {QDIV_W{1'h0}});
	assign end_of_char = (s.st == TX_SEND) && tx_tick && (s.qcnt == Q_LAST)
		&& (s.bitcnt == TX_STOP_IDX);

	always_comb
	begin
		next_ = s;
		tx_load = 1'h0;

		// One-character holding register; the next character waits here during the current one
		if (tx_valid_i && s.tx_ready)
		begin
			next_.hold = tx_data_i;
			next_.hold_valid = 1'h1;
		end

		unique case (s.st)
			TX_IDLE:
			begin
				if (s.hold_valid)
				begin
					next_.st = TX_WAIT;
					next_.rts = 1'h1;
					next_.oe = 1'h1;
				end
			end
			TX_WAIT:
			begin
				if (!cts_n)
				begin
					tx_load = 1'h1;
				end
			end
			TX_SEND:
			begin
				if (tx_tick)
				begin
					next_.div = qdiv_reload(quarter_div_i);
					next_.qcnt = s.qcnt + 2'h1;
				end
				else
				begin
					next_.div = s.div - {{(QDIV_W-1){1'h0}}, 1'h1};
				end
				if (end_of_char)
				begin
					if (s.hold_valid && !cts_n)
					begin
						tx_load = 1'h1;
					end
					else if (s.hold_valid)
					begin
						// Modem withdrew clear-to-send: keep the line owned and wait
						next_.st = TX_WAIT;
					end
					else
					begin
						next_.st = TX_IDLE;
						next_.rts = 1'h0;
						next_.oe = 1'h0;
					end
				end
				else if (tx_tick && s.qcnt == Q_LAST)
				begin
					next_.shreg = {1'h1, s.shreg[10:1]};
					next_.bitcnt = s.bitcnt + 4'h1;
				end
			end
			default:
			begin
				next_.st = TX_IDLE;
				next_.rts = 1'h0;
				next_.oe = 1'h0;
			end
		endcase

		if (tx_load)
		begin
			next_.st = TX_SEND;
			next_.shreg = frame_of(s.hold);
			next_.cur = s.hold;
			next_.bitcnt = 4'h0;
			next_.qcnt = 2'h0;
			next_.div = qdiv_reload(quarter_div_i);
			next_.hold_valid = 1'h0;
		end

		next_.txd = (next_.st == TX_SEND) ? next_.shreg[0] : LINE_IDLE;
		next_.tx_ready = !next_.hold_valid;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s <= '{st: TX_IDLE, div: {QDIV_W{1'h0}}, qcnt: 2'h0, bitcnt: 4'h0, shreg: 11'h7FF,
				cur: DATA_RESET, hold: DATA_RESET, hold_valid: 1'h0, tx_ready: 1'h1,
				txd: LINE_IDLE, oe: 1'h0, rts: 1'h0};
		end
		else
		begin
			s <= next_;
		end
	end

	assign tx_ready_o = s.tx_ready;
	assign txd_o = s.txd;
	assign txd_oe_o = s.oe;
	assign rts_o = s.rts;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_rts_first;
		@(posedge clk_i) disable iff (rst_i)
		$rose(s.st == TX_SEND) |-> $past(s.rts) && rts_o;
	endproperty
	a_rts_first: assert property (p_rts_first) else $error("character started without rts");

	property p_cts_hold;
		@(posedge clk_i) disable iff (rst_i)
		s.st == TX_WAIT && cts_n |=> s.st == TX_WAIT && txd_o == LINE_IDLE;
	endproperty
	a_cts_hold: assert property (p_cts_hold) else $error("sent while clear-to-send inactive");

	property p_cts_recheck;
		@(posedge clk_i) disable iff (rst_i)
		end_of_char && s.hold_valid && cts_n |=> s.st == TX_WAIT && rts_o && txd_o;
	endproperty
	a_cts_recheck: assert property (p_cts_recheck) else $error("next char ignored clear-to-send");

	property p_back_to_back;
		@(posedge clk_i) disable iff (rst_i)
		end_of_char && s.hold_valid && !cts_n |=> s.st == TX_SEND && !txd_o && s.bitcnt == 4'h0;
	endproperty
	a_back_to_back: assert property (p_back_to_back) else $error("gap between characters");

	property p_data_bits;
		@(posedge clk_i) disable iff (rst_i)
		s.st == TX_SEND && s.bitcnt >= 4'h1 && s.bitcnt <= 4'h8
			|-> txd_o == s.cur[3'(s.bitcnt - 4'h1)];
	endproperty
	a_data_bits: assert property (p_data_bits) else $error("data bit mismatch on line");

	property p_framing;
		@(posedge clk_i) disable iff (rst_i)
		s.st == TX_SEND
			|-> (s.bitcnt == 4'h0 && !txd_o) || (s.bitcnt == TX_PARITY_IDX && txd_o == ^s.cur)
			|| (s.bitcnt == TX_STOP_IDX && txd_o) || (s.bitcnt >= 4'h1 && s.bitcnt <= 4'h8);
	endproperty
	a_framing: assert property (p_framing) else $error("start, parity or stop bit wrong");

	property p_rts_release;
		@(posedge clk_i) disable iff (rst_i)
		$fell(rts_o) |-> $past(end_of_char) && !$past(s.hold_valid);
	endproperty
	a_rts_release: assert property (p_rts_release) else $error("rts dropped mid-character");

	property p_quarter_step;
		@(posedge clk_i) disable iff (rst_i)
		s.st == TX_SEND && !tx_tick && !tx_load |=> s.qcnt == $past(s.qcnt);
	endproperty
	a_quarter_step: assert property (p_quarter_step) else $error("quarter advanced off tick");

	// The transceiver only drives the bus while the telegram owns it
	property p_oe_with_rts;
		@(posedge clk_i) disable iff (rst_i)
		txd_oe_o == rts_o;
	endproperty
	a_oe_with_rts: assert property (p_oe_with_rts) else $error("line enable apart from rts");

	property p_released_idle;
		@(posedge clk_i) disable iff (rst_i)
		!txd_oe_o |-> txd_o == LINE_IDLE;
	endproperty
	a_released_idle: assert property (p_released_idle) else $error("data on released line");

	property p_wait_owns_line;
		@(posedge clk_i) disable iff (rst_i)
		s.st == TX_WAIT |-> rts_o && txd_o == LINE_IDLE;
	endproperty
	a_wait_owns_line: assert property (p_wait_owns_line) else $error("wait without rts");

	property p_bit_advance;
		@(posedge clk_i) disable iff (rst_i)
		s.st == TX_SEND && tx_tick && s.qcnt == Q_LAST && s.bitcnt != TX_STOP_IDX
			|=> s.bitcnt == $past(s.bitcnt) + 4'h1;
	endproperty
	a_bit_advance: assert property (p_bit_advance) else $error("bit not advanced");

	// A received character is announced exactly once
	property p_rx_one_pulse;
		@(posedge clk_i) disable iff (rst_i)
		rx_valid_o |=> !rx_valid_o;
	endproperty
	a_rx_one_pulse: assert property (p_rx_one_pulse) else $error("rx valid held");

	// ****************************************************************
	// Coverage
	// ****************************************************************
	c_back_to_back: cover property (@(posedge clk_i) disable iff (rst_i)
		end_of_char && s.hold_valid && !cts_n);
	c_cts_pause: cover property (@(posedge clk_i) disable iff (rst_i)
		end_of_char && s.hold_valid && cts_n);
	c_rx_char: cover property (@(posedge clk_i) disable iff (rst_i)
		rx_valid_o && !rx_parity_err_o && !rx_frame_err_o);
	c_rx_error: cover property (@(posedge clk_i) disable iff (rst_i)
		rx_valid_o && (rx_parity_err_o || rx_frame_err_o));
	c_telegram_end: cover property (@(posedge clk_i) disable iff (rst_i)
		$fell(rts_o));

endmodule

`default_nettype wire

//--- hw/fieldbus_uart_pkg.sv
// Shared constants, state types and helpers of the fieldbus serial UART

`default_nettype none

package fieldbus_uart_pkg;

	// ****************************************************************
	// Widths, indices and reset values
	// ****************************************************************
	localparam int QDIV_W = 16;
	localparam logic [3:0] TX_PARITY_IDX = 4'h9;
	localparam logic [3:0] TX_STOP_IDX = 4'hA;
	localparam logic [3:0] RX_STOP_IDX = 4'h9;
	localparam logic [1:0] Q_LAST = 2'h3;
	localparam logic [1:0] Q_START_MID = 2'h1;
	localparam logic LINE_IDLE = 1'h1;
	localparam logic CTS_INACTIVE = 1'h1;
	localparam logic [7:0] DATA_RESET = 8'h00;

	// ****************************************************************
	// State types
	// ****************************************************************
	typedef enum logic [2:0]
	{
		TX_IDLE = 3'h1,
		TX_WAIT = 3'h2,
		TX_SEND = 3'h4
	} tx_state_t;

	typedef enum logic [2:0]
	{
		RX_IDLE = 3'h1,
		RX_START = 3'h2,
		RX_BITS = 3'h4
	} rx_state_t;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// A zero divisor would stall the tick, so it is treated as one cycle per quarter
	function automatic logic [QDIV_W-1:0] qdiv_reload(input logic [QDIV_W-1:0] qdiv);
		qdiv_reload = (qdiv == {QDIV_W{1'h0}}) ? {QDIV_W{1'h0}} : qdiv - {{(QDIV_W-1){1'h0}}, 1'h1};
	endfunction

	function automatic logic [10:0] frame_of(input logic [7:0] d);
		frame_of = {1'h1, ^d, d, 1'h0};
	endfunction

endpackage

`default_nettype wire

//--- hw/serial_receiver.sv
// Four-fold oversampling receiver of the fieldbus serial UART
`default_nettype none

module serial_receiver
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Line and configuration
	input wire logic rxd_i,
	input wire logic [fieldbus_uart_pkg::QDIV_W-1:0] quarter_div_i,
	input wire logic stop_check_dis_i,
	input wire logic start_check_dis_i,
	// Received character
	output logic [7:0] data_o,
	output logic valid_o,
	output logic parity_err_o,
	output logic frame_err_o
);
	import fieldbus_uart_pkg::*;

	typedef struct packed
	{
		rx_state_t st;
		logic [QDIV_W-1:0] div;
		logic [1:0] qcnt;
		logic [3:0] bitcnt;
		logic [8:0] shreg;
		logic prev;
		logic [7:0] data;
		logic valid;
		logic perr;
		logic ferr;
	} rx_regs_t;

	rx_regs_t s;
	rx_regs_t next_;
	logic tick;

	assign tick = (s.div == {QDIV_W{1'h0}});

	always_comb
	begin
		next_ = s;
		next_.prev = rxd_i;
		next_.valid = 1'h0;
		next_.div = tick ? qdiv_reload(quarter_div_i) : s.div - {{(QDIV_W-1){1'h0}}, 1'h1};
		if (tick)
		begin
			next_.qcnt = s.qcnt + 2'h1;
		end
		unique case (s.st)
			RX_IDLE:
			begin
				if (s.prev && !rxd_i)
				begin
					next_.st = RX_START;
					next_.div = qdiv_reload(quarter_div_i);
					next_.qcnt = 2'h0;
				end
			end
			RX_START:
			begin
				if (tick && s.qcnt == Q_START_MID)
				begin
					// Skipping the check lets a start edge shifted by stop-bit distortion through
					if (!rxd_i || start_check_dis_i)
					begin
						next_.st = RX_BITS;
						next_.qcnt = 2'h0;
						next_.bitcnt = 4'h0;
					end
					else
					begin
						next_.st = RX_IDLE;
					end
				end
			end
			RX_BITS:
			begin
				if (tick && s.qcnt == Q_LAST)
				begin
					if (s.bitcnt == RX_STOP_IDX)
					begin
						next_.st = RX_IDLE;
						next_.valid = 1'h1;
						next_.data = s.shreg[7:0];
						next_.perr = ^s.shreg;
						next_.ferr = !stop_check_dis_i && !rxd_i;
					end
					else
					begin
						next_.shreg = {rxd_i, s.shreg[8:1]};
						next_.bitcnt = s.bitcnt + 4'h1;
					end
				end
			end
			default:
			begin
				next_.st = RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s <= '{st: RX_IDLE, div: {QDIV_W{1'h0}}, qcnt: 2'h0, bitcnt: 4'h0, shreg: 9'h000,
				prev: LINE_IDLE, data: DATA_RESET, valid: 1'h0, perr: 1'h0, ferr: 1'h0};
		end
		else
		begin
			s <= next_;
		end
	end

	assign data_o = s.data;
	assign valid_o = s.valid;
	assign parity_err_o = s.perr;
	assign frame_err_o = s.ferr;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_rx_edge;
		@(posedge clk_i) disable iff (rst_i)
		s.st == RX_IDLE && s.prev && !rxd_i |=> s.st == RX_START;
	endproperty
	a_rx_edge: assert property (p_rx_edge) else $error("falling edge did not start sync");

	property p_rx_false_start;
		@(posedge clk_i) disable iff (rst_i)
		s.st == RX_START && tick && s.qcnt == Q_START_MID && rxd_i && !start_check_dis_i
			|=> s.st == RX_IDLE;
	endproperty
	a_rx_false_start: assert property (p_rx_false_start) else $error("high start accepted");

	property p_rx_start_relaxed;
		@(posedge clk_i) disable iff (rst_i)
		s.st == RX_START && tick && s.qcnt == Q_START_MID && start_check_dis_i |=> s.st == RX_BITS;
	endproperty
	a_rx_start_relaxed: assert property (p_rx_start_relaxed) else $error("relaxed start lost");

	property p_rx_stop_skip;
		@(posedge clk_i) disable iff (rst_i)
		s.st == RX_BITS && tick && s.qcnt == Q_LAST && s.bitcnt == RX_STOP_IDX && stop_check_dis_i
			|=> valid_o && !frame_err_o;
	endproperty
	a_rx_stop_skip: assert property (p_rx_stop_skip) else $error("stop checked while disabled");

	property p_rx_mid_only;
		@(posedge clk_i) disable iff (rst_i)
		s.st == RX_BITS && !(tick && s.qcnt == Q_LAST) |=> s.shreg == $past(s.shreg);
	endproperty
	a_rx_mid_only: assert property (p_rx_mid_only) else $error("bit sampled off mid-bit");

endmodule

`default_nettype wire

//--- test/line_partner.sv
// Behavioural RS485 transceiver and modem on the far side of the fieldbus UART
`default_nettype none

module line_partner
#(
	parameter int Q = 2
)
(
	// Clock
	input wire logic clk_i,
	// Device side pins
	input wire logic txd_i,
	input wire logic txd_oe_i,
	input wire logic rts_i,
	output var logic rxd_o,
	output var logic modem_clear_in_n_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Decoded frames: {rts at start, start, stop, parity, data}
	logic [11:0] frames[$];
	int starts[$];
	int cycle = 0;
	logic [11:0] f;
	logic line;

	// External pull-up holds the released line high
	assign line = txd_oe_i ? txd_i : 1'h1;

	initial
	begin
		rxd_o = 1'h1;
		modem_clear_in_n_o = 1'h1;
	end

	always @(posedge clk_i)
		cycle <= cycle + 1;

	// ****************************************************************
	// Frame decoder, mid-bit sampling like a real station
	// ****************************************************************
	initial
	forever
	begin
		@(posedge clk_i);
		if (line === 1'h0)
		begin
			starts.push_back(cycle);
			f[11] = rts_i;
			repeat (2 * Q - 1) @(posedge clk_i);
			f[10] = line;
			for (int i = 0; i < 10; i++)
			begin
				repeat (4 * Q) @(posedge clk_i);
				f[i] = line;
			end
			frames.push_back(f);
		end
	end

	// ****************************************************************
	// Line and modem stimulus
	// ****************************************************************
	task automatic send_char(input logic [7:0] d, input logic bad_par, input logic bad_stop);
		logic [10:0] bits;
		bits = {~bad_stop, (^d) ^ bad_par, d, 1'h0};
		for (int i = 0; i < 11; i++)
		begin
			@(posedge clk_i);
			rxd_o <= bits[i];
			repeat (4 * Q - 1) @(posedge clk_i);
		end
		@(posedge clk_i);
		rxd_o <= 1'h1;
		repeat (8 * Q) @(posedge clk_i);
	endtask

	// Short low pulse that no real start bit could be
	task automatic glitch(input int n);
		@(posedge clk_i);
		rxd_o <= 1'h0;
		repeat (n) @(posedge clk_i);
		rxd_o <= 1'h1;
		repeat (50 * Q) @(posedge clk_i);
	endtask

	task automatic set_cts(input logic v);
		@(posedge clk_i);
		modem_clear_in_n_o <= v;
	endtask

endmodule

`default_nettype wire

//--- test/tb_top.sv
// Self-checking testbench of the fieldbus serial UART
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fieldbus_uart_pkg::*;

	localparam int Q = 2;

	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [QDIV_W-1:0] quarter_div = 16'h0002;
	logic stop_dis = 1'h0;
	logic start_dis = 1'h0;
	logic [7:0] tx_data = 8'h00;
	logic tx_valid = 1'h0;
	wire logic tx_ready, rx_valid, rx_perr, rx_ferr, rxd, cts_n, txd, txd_oe, rts;
	wire logic [7:0] rx_data;
	int failures = 0;
	int checks = 0;
	int rx_count = 0;
	logic [9:0] rx_last = 10'h000;

	fieldbus_serial_uart dut
	(
		.clk_i(clk), .rst_i(rst), .quarter_div_i(quarter_div),
		.stop_check_dis_i(stop_dis), .start_check_dis_i(start_dis),
		.tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
		.rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_parity_err_o(rx_perr),
		.rx_frame_err_o(rx_ferr), .rxd_i(rxd), .modem_clear_in_n_i(cts_n),
		.txd_o(txd), .txd_oe_o(txd_oe), .rts_o(rts)
	);

	line_partner #(.Q(Q)) partner
	(
		.clk_i(clk), .txd_i(txd), .txd_oe_i(txd_oe), .rts_i(rts),
		.rxd_o(rxd), .modem_clear_in_n_o(cts_n)
	);

	initial
	begin
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
		if (rx_valid === 1'h1)
		begin
			rx_count <= rx_count + 1;
			rx_last <= {rx_ferr, rx_perr, rx_data};
		end

	// ****************************************************************
	// Shared helpers
	// ****************************************************************
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic put_char(input logic [7:0] d);
		@(posedge clk);
		tx_data <= d;
		tx_valid <= 1'h1;
		for (int k = 0; k < 400; k++)
		begin
			@(posedge clk);
			if (tx_ready === 1'h1)
				break;
		end
		tx_valid <= 1'h0;
	endtask

	task automatic wait_frames(input int n);
		for (int k = 0; k < 3000 && partner.frames.size() < n; k++)
			@(posedge clk);
		check("frame count", n, partner.frames.size());
	endtask

	function automatic logic [11:0] exp_frame(input logic [7:0] d);
		exp_frame = {1'h1, 1'h0, 1'h1, ^d, d};
	endfunction

	task automatic complete_run();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		@(posedge clk);
		check("txd idle", 1, txd);
		check("txd_oe", 0, txd_oe);
		check("rts", 0, rts);
		check("tx_ready", 1, tx_ready);
		check("rx_valid", 0, rx_valid);
		check("rx_data", 0, rx_data);
		$display("test reset done");
	endtask

	// Three characters back to back, then the line is given up
	task automatic t_telegram();
		logic [7:0] d[3];
		d = '{8'h01, 8'hA5, 8'h80};
		partner.frames.delete();
		partner.starts.delete();
		partner.set_cts(1'h0);
		repeat (4) @(posedge clk);
		for (int i = 0; i < 3; i++)
			put_char(d[i]);
		wait_frames(3);
		check("rts at last stop", 1, rts);
		for (int i = 0; i < 3; i++)
			check("tx frame", exp_frame(d[i]), partner.frames[i]);
		for (int i = 0; i < 2; i++)
			check("char gap", 44 * Q, partner.starts[i + 1] - partner.starts[i]);
		repeat (2 * Q + 4) @(posedge clk);
		check("rts released", 0, rts);
		check("txd_oe released", 0, txd_oe);
		$display("test telegram done");
	endtask

	// Clear-to-send gates the first character and every later one
	task automatic t_cts();
		partner.frames.delete();
		partner.set_cts(1'h1);
		put_char(8'h5A);
		repeat (100) @(posedge clk);
		check("rts while waiting", 1, rts);
		check("held first char", 0, partner.frames.size());
		check("txd idle while held", 1, txd);
		partner.set_cts(1'h0);
		for (int k = 0; k < 200 && txd !== 1'h0; k++)
			@(posedge clk);
		partner.set_cts(1'h1);
		put_char(8'hC3);
		wait_frames(1);
		repeat (100) @(posedge clk);
		check("held next char", 1, partner.frames.size());
		check("rts kept", 1, rts);
		partner.set_cts(1'h0);
		wait_frames(2);
		check("first frame", exp_frame(8'h5A), partner.frames[0]);
		check("second frame", exp_frame(8'hC3), partner.frames[1]);
		repeat (4 * Q) @(posedge clk);
		$display("test cts done");
	endtask

	task automatic rx_case(input logic [7:0] d, input logic bp, input logic bs, input logic sd,
		input logic ep, input logic ef);
		int n0;
		n0 = rx_count;
		@(posedge clk);
		stop_dis <= sd;
		partner.send_char(d, bp, bs);
		check("rx count", n0 + 1, rx_count);
		check("rx char", {ef, ep, d}, rx_last);
	endtask

	task automatic t_rx();
		rx_case(8'hA5, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
		rx_case(8'h3C, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
		rx_case(8'h81, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1);
		rx_case(8'h81, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
		$display("test rx done");
	endtask

	// A short low pulse is dropped unless the start check is off
	task automatic t_glitch();
		int n0;
		n0 = rx_count;
		partner.glitch(Q);
		check("glitch dropped", n0, rx_count);
		@(posedge clk);
		start_dis <= 1'h1;
		partner.glitch(Q);
		check("glitch taken", n0 + 1, rx_count);
		check("glitch char", {1'h0, 1'h1, 8'hFF}, rx_last);
		rx_case(8'h96, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
		@(posedge clk);
		start_dis <= 1'h0;
		$display("test glitch done");
	endtask

	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		t_reset();
		t_telegram();
		t_cts();
		t_rx();
		t_glitch();
		complete_run();
	end

	// Whole run needs about 1500 cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		complete_run();
	end

endmodule

`default_nettype wire
